// >>> rtl/ccm_top.sv
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
module ccm_top #(
	parameter int CW = 16, // timer and capture width
	parameter int DTW = 6 // dead-time counter width
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// channel pins
	input wire logic [2:0] chan_pin_i,
	output logic [2:0] chan_pin_o,
	output logic [2:0] chan_pin_oe_n_o,
	output logic [2:0] chan_complement_pin_o,
	output logic [2:0] chan_complement_pin_oe_n_o,
	// position inputs and second timer events
	input wire logic [2:0] position_input_i,
	input wire logic second_timer_cmp_i,
	input wire logic second_timer_per_i
);
	ccm_edge_if #(.N(6)) eif ();
	logic ack_ff; // bus answer
	logic [31:0] rdat_ff; // read data
	logic run_ff; // timer running
	logic center_ff; // center-aligned mode
	logic down_ff; // counting down
	logic soft_hall_ff; // one-cycle soft_hall_trigger pulse
	logic [CW-1:0] count_ff; // main_pwm_timer value
	logic [CW-1:0] period_ff; // main_period_value
	logic [DTW-1:0] dt_val_ff; // dead-time reload
	logic [15:0] mode_sel_ff; // channel_mode_select
	logic [CW-1:0] main_ff [3]; // chan_main_value
	logic [CW-1:0] shadow_ff [3]; // chan_shadow_value
	logic [2:0] state_ff; // chan_state_bit
	logic [2:0] state_prev_ff; // state bit last cycle
	logic [DTW-1:0] dtc_ff [3]; // dead-time counters, index 0 is deadtime_counter_zero
	logic hall_pend_ff; // hall sampling waits on counter 0
	logic [2:0] hall_pat_ff; // last sampled hall pattern
	logic [2:0] pin_o_ff, pin_oe_n_ff, comp_o_ff, comp_oe_n_ff; // pin drivers
	logic wr_en; // write strobe this cycle
	logic rd_en; // read strobe this cycle
	logic [3:0] mode [3]; // per-channel mode fields
	logic [2:0] hall_src; // hall sampling source
	logic bypass; // delay_bypass
	logic hall_all; // all three channels in hall mode
	logic per_match; // count at period
	logic hw_trig; // selected hardware hall trigger
	logic hall_trig; // any hall trigger
	logic hall_sample; // sample hall inputs now
	logic hall_valid; // sampled pattern changed
	logic [2:0] cmp_match; // count equals main value
	logic [CW-1:0] nxt_count; // next timer value

	// raw pins into the edge detector: channel pins low, position inputs high
	assign eif.raw = {position_input_i, chan_pin_i};
	ccm_edge_det #(.N(6)) u_edge (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.e(eif)
	);

	// mode select fields
	assign mode[0] = mode_sel_ff[ccm_pkg::CHAN0_MODE_LSB +: ccm_pkg::MODE_W];
	assign mode[1] = mode_sel_ff[ccm_pkg::CHAN1_MODE_LSB +: ccm_pkg::MODE_W];
	assign mode[2] = mode_sel_ff[ccm_pkg::CHAN2_MODE_LSB +: ccm_pkg::MODE_W];
	assign hall_src = mode_sel_ff[ccm_pkg::HALL_SRC_LSB +: ccm_pkg::HALL_SRC_W];
	assign bypass = mode_sel_ff[ccm_pkg::DELAY_BYPASS_BIT];

	// bus strobes: one access per ack
	assign wr_en = wb_cyc_i & wb_stb_i & ~ack_ff & wb_we_i;
	assign rd_en = wb_cyc_i & wb_stb_i & ~ack_ff & ~wb_we_i;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
		merge16 = old;
		if (sel[0])
			merge16[7:0] = d[7:0];
		if (sel[1])
			merge16[15:8] = d[15:8];
	endfunction

	// hall enable only when every channel is in hall mode
	assign hall_all = (mode[0] == ccm_pkg::MODE_HALL) && (mode[1] == ccm_pkg::MODE_HALL)
		&& (mode[2] == ccm_pkg::MODE_HALL);
	assign per_match = (count_ff == period_ff) && !down_ff;

	// hardware hall trigger source
	always_comb
	begin
		unique case (hall_src)
			ccm_pkg::HSRC_POS_EDGE: hw_trig = |(eif.rise[5:3] | eif.fall[5:3]);
			ccm_pkg::HSRC_SEC_CMP: hw_trig = second_timer_cmp_i;
			ccm_pkg::HSRC_SEC_PER: hw_trig = second_timer_per_i;
			ccm_pkg::HSRC_PER_UP: hw_trig = per_match;
			ccm_pkg::HSRC_ONE_DOWN: hw_trig = down_ff && (count_ff == CW'(1));
			ccm_pkg::HSRC_CMP0_UP: hw_trig = cmp_match[0] && !down_ff;
			ccm_pkg::HSRC_NONE, ccm_pkg::HSRC_UNDEF: hw_trig = 1'b0;
		endcase
	end

	// software trigger joins any source
	assign hall_trig = hall_all && (hw_trig || soft_hall_ff);
	// sample at once on bypass, else when counter 0 reaches one
	assign hall_sample = hall_all && ((hall_trig && bypass)
		|| (hall_pend_ff && dtc_ff[0] == DTW'(ccm_pkg::HALL_SAMPLE_CNT)));
	assign hall_valid = hall_sample && (eif.level[5:3] != hall_pat_ff);

	// hall pending flag and pattern store
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			hall_pend_ff <= 1'b0;
			hall_pat_ff <= 3'h0;
		end
		else
		begin
			if (hall_sample)
				hall_pend_ff <= 1'b0;
			else if (hall_trig && !bypass)
				hall_pend_ff <= 1'b1;
			if (hall_sample)
				hall_pat_ff <= eif.level[5:3];
		end
	end

	// next timer value
	always_comb
	begin
		nxt_count = count_ff;
		if (hall_valid)
			nxt_count = '0;
		else if (wr_en && wb_adr_i == ccm_pkg::OFS_COUNT && !run_ff)
			nxt_count = merge16(count_ff, wb_dat_i, wb_sel_i);
		else if (run_ff)
		begin
			if (!center_ff)
				nxt_count = per_match ? '0 : CW'(count_ff + 1'b1);
			else if (down_ff)
				nxt_count = CW'(count_ff - 1'b1);
			else if (!per_match)
				nxt_count = CW'(count_ff + 1'b1);
		end
	end

	// timer counter and direction
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_ff <= ccm_pkg::VALUE_RST;
			down_ff <= 1'b0;
		end
		else
		begin
			count_ff <= nxt_count;
			if (!center_ff || hall_valid)
				down_ff <= 1'b0;
			else if (run_ff && per_match)
				down_ff <= 1'b1;
			else if (run_ff && down_ff && count_ff == CW'(1))
				down_ff <= 1'b0;
		end
	end

	// control, period, dead-time and mode registers
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			run_ff <= 1'b0;
			center_ff <= 1'b0;
			soft_hall_ff <= 1'b0;
			period_ff <= ccm_pkg::VALUE_RST;
			dt_val_ff <= ccm_pkg::DEADTIME_RST;
			mode_sel_ff <= ccm_pkg::MODE_SEL_RST;
		end
		else
		begin
			soft_hall_ff <= wr_en && wb_adr_i == ccm_pkg::OFS_CTRL && wb_sel_i[0]
				&& wb_dat_i[ccm_pkg::CTRL_SOFT_HALL_BIT];
			if (wr_en && wb_adr_i == ccm_pkg::OFS_CTRL && wb_sel_i[0])
			begin
				run_ff <= wb_dat_i[ccm_pkg::CTRL_RUN_BIT];
				center_ff <= wb_dat_i[ccm_pkg::CTRL_CENTER_BIT];
			end
			if (wr_en && wb_adr_i == ccm_pkg::OFS_PERIOD)
				period_ff <= merge16(period_ff, wb_dat_i, wb_sel_i);
			if (wr_en && wb_adr_i == ccm_pkg::OFS_DEADTIME && wb_sel_i[0])
				dt_val_ff <= wb_dat_i[DTW-1:0];
			if (wr_en && wb_adr_i == ccm_pkg::OFS_MODE_SEL)
				mode_sel_ff <= merge16(mode_sel_ff, wb_dat_i, wb_sel_i);
		end
	end

	// per-channel capture, compare, dead time and pins
	for (genvar n = 0; n < 3; n++)
	begin : g_chan
		logic p_r, p_f, q_r, q_f, p_any, q_any; // pin and position edges
		logic is_cmp; // channel runs a compare mode
		logic drv_pin, drv_comp; // pin routing
		logic sh_wr; // software write to shadow
		assign p_r = eif.rise[n];
		assign p_f = eif.fall[n];
		assign q_r = eif.rise[n+3];
		assign q_f = eif.fall[n+3];
		assign p_any = p_r | p_f;
		assign q_any = q_r | q_f;
		assign cmp_match[n] = (count_ff == main_ff[n]);
		assign sh_wr = wr_en && wb_adr_i == 8'(ccm_pkg::OFS_SHADOW0 + ccm_pkg::OFS_CHAN_STEP * n);
		assign drv_pin = mode[n] == ccm_pkg::MODE_CMP_PIN || mode[n] == ccm_pkg::MODE_CMP_BOTH
			|| mode[n] == ccm_pkg::MODE_HYST || (mode[n] == ccm_pkg::MODE_HALL && n != 0);
		assign drv_comp = mode[n] == ccm_pkg::MODE_CMP_COMP || mode[n] == ccm_pkg::MODE_CMP_BOTH;
		assign is_cmp = drv_pin || drv_comp;

		// capture into main and shadow; hardware wins over a bus write
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				main_ff[n] <= ccm_pkg::VALUE_RST;
				shadow_ff[n] <= ccm_pkg::VALUE_RST;
			end
			else
			begin
				if (sh_wr)
					shadow_ff[n] <= merge16(shadow_ff[n], wb_dat_i, wb_sel_i);
				if (is_cmp && (per_match || !run_ff))
					main_ff[n] <= shadow_ff[n];
				unique case (mode[n])
					ccm_pkg::MODE_DBL_SPLIT:
					begin
						if (p_r)
							main_ff[n] <= count_ff;
						if (p_f)
							shadow_ff[n] <= count_ff;
					end
					ccm_pkg::MODE_DBL_RISE, ccm_pkg::MODE_DBL_FALL, ccm_pkg::MODE_DBL_ANY:
						if ((mode[n] == ccm_pkg::MODE_DBL_RISE && p_r) || (mode[n] == ccm_pkg::MODE_DBL_FALL && p_f)
							|| (mode[n] == ccm_pkg::MODE_DBL_ANY && p_any))
						begin
							main_ff[n] <= shadow_ff[n];
							shadow_ff[n] <= count_ff;
						end
					ccm_pkg::MODE_HALL:
						if (n == 0 && hall_valid)
							main_ff[n] <= count_ff;
					ccm_pkg::MODE_MI_RF, ccm_pkg::MODE_MI_FR:
					begin
						if (mode[n] == ccm_pkg::MODE_MI_RF ? p_r : p_f)
							main_ff[n] <= count_ff;
						if (mode[n] == ccm_pkg::MODE_MI_RF ? q_f : q_r)
							shadow_ff[n] <= count_ff;
					end
					ccm_pkg::MODE_MI_RR, ccm_pkg::MODE_MI_FF, ccm_pkg::MODE_MI_ANY:
					begin
						if ((mode[n] == ccm_pkg::MODE_MI_RR && p_r) || (mode[n] == ccm_pkg::MODE_MI_FF && p_f)
							|| (mode[n] == ccm_pkg::MODE_MI_ANY && p_any))
							main_ff[n] <= count_ff;
						if ((mode[n] == ccm_pkg::MODE_MI_RR && q_r) || (mode[n] == ccm_pkg::MODE_MI_FF && q_f)
							|| (mode[n] == ccm_pkg::MODE_MI_ANY && q_any))
							shadow_ff[n] <= count_ff;
					end
					ccm_pkg::MODE_OFF, ccm_pkg::MODE_CMP_PIN, ccm_pkg::MODE_CMP_COMP, ccm_pkg::MODE_CMP_BOTH,
					ccm_pkg::MODE_HYST, ccm_pkg::MODE_RSVD: ;
				endcase
			end
		end

		// compare state bit
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				state_ff[n] <= 1'b0;
			else if (!is_cmp)
				state_ff[n] <= 1'b0;
			else if (mode[n] == ccm_pkg::MODE_HYST && q_f)
				state_ff[n] <= 1'b0;
			else if (run_ff && cmp_match[n] && !down_ff)
				state_ff[n] <= (mode[n] != ccm_pkg::MODE_HYST) || eif.level[n+3];
			else if (mode[n] != ccm_pkg::MODE_HYST && run_ff && (cmp_match[n] && down_ff || per_match && !center_ff))
				state_ff[n] <= 1'b0;
		end

		// dead-time counter; reload only while at zero
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				dtc_ff[n] <= '0;
			else if (dtc_ff[n] == '0 && ((state_ff[n] != state_prev_ff[n])
				|| (n == 0 && hall_trig && !bypass)))
				dtc_ff[n] <= dt_val_ff;
			else if (dtc_ff[n] != '0)
				dtc_ff[n] <= DTW'(dtc_ff[n] - 1'b1);
		end

		// pin drivers; passive at once, active after dead time
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				state_prev_ff[n] <= 1'b0;
				pin_o_ff[n] <= 1'b0;
				comp_o_ff[n] <= 1'b0;
				pin_oe_n_ff[n] <= 1'b1;
				comp_oe_n_ff[n] <= 1'b1;
			end
			else
			begin
				state_prev_ff[n] <= state_ff[n];
				pin_o_ff[n] <= state_ff[n] && state_prev_ff[n] && dtc_ff[n] == '0;
				comp_o_ff[n] <= !state_ff[n] && !state_prev_ff[n] && dtc_ff[n] == '0;
				pin_oe_n_ff[n] <= !drv_pin;
				comp_oe_n_ff[n] <= !drv_comp;
			end
		end
	end

	// bus answer and read mux
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0;
		end
		else
		begin
			ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
			if (rd_en)
			begin
				rdat_ff <= 32'h0;
				unique case (wb_adr_i)
					ccm_pkg::OFS_CTRL: rdat_ff[3:0] <= {down_ff, 1'b0, center_ff, run_ff};
					ccm_pkg::OFS_PERIOD: rdat_ff[CW-1:0] <= period_ff;
					ccm_pkg::OFS_DEADTIME: rdat_ff[DTW-1:0] <= dt_val_ff;
					ccm_pkg::OFS_MODE_SEL: rdat_ff[15:0] <= mode_sel_ff;
					ccm_pkg::OFS_COUNT: rdat_ff[CW-1:0] <= count_ff;
					ccm_pkg::OFS_STATUS: rdat_ff[5:0] <= {hall_pat_ff, state_ff};
					ccm_pkg::OFS_SHADOW0: rdat_ff[CW-1:0] <= shadow_ff[0];
					8'(ccm_pkg::OFS_SHADOW0 + ccm_pkg::OFS_CHAN_STEP): rdat_ff[CW-1:0] <= shadow_ff[1];
					8'(ccm_pkg::OFS_SHADOW0 + ccm_pkg::OFS_CHAN_STEP * 2): rdat_ff[CW-1:0] <= shadow_ff[2];
					ccm_pkg::OFS_MAIN0: rdat_ff[CW-1:0] <= main_ff[0];
					8'(ccm_pkg::OFS_MAIN0 + ccm_pkg::OFS_CHAN_STEP): rdat_ff[CW-1:0] <= main_ff[1];
					8'(ccm_pkg::OFS_MAIN0 + ccm_pkg::OFS_CHAN_STEP * 2): rdat_ff[CW-1:0] <= main_ff[2];
					default: rdat_ff <= 32'h0;
				endcase
			end
		end
	end

	// outputs straight from flip-flops
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign chan_pin_o = pin_o_ff;
	assign chan_pin_oe_n_o = pin_oe_n_ff;
	assign chan_complement_pin_o = comp_o_ff;
	assign chan_complement_pin_oe_n_o = comp_oe_n_ff;
endmodule

// >>> rtl/ccm_pkg.sv
// shared constants of the capture/compare mode block
package ccm_pkg;

	// register byte offsets on the bus
	localparam logic [7:0] OFS_CTRL = 8'h00; // run, alignment, soft hall trigger
	localparam logic [7:0] OFS_SHADOW0 = 8'h14; // chan_shadow_value, channel 0; +4 per channel
	localparam logic [7:0] OFS_PERIOD = 8'h24; // main_period_value
	localparam logic [7:0] OFS_DEADTIME = 8'h2c; // dead-time reload value
	localparam logic [7:0] OFS_MAIN0 = 8'h34; // chan_main_value, channel 0; +4 per channel
	localparam logic [7:0] OFS_MODE_SEL = 8'h40; // channel_mode_select
	localparam logic [7:0] OFS_COUNT = 8'h78; // main_timer_count
	localparam logic [7:0] OFS_STATUS = 8'h80; // state bits and hall pattern
	localparam logic [7:0] OFS_CHAN_STEP = 8'h04; // spacing of per-channel registers

	// control register bits
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_CENTER_BIT = 1;
	localparam int CTRL_SOFT_HALL_BIT = 2;
	localparam int CTRL_DOWN_BIT = 3;

	// channel_mode_select fields
	localparam int CHAN0_MODE_LSB = 0;
	localparam int CHAN1_MODE_LSB = 4;
	localparam int CHAN2_MODE_LSB = 8;
	localparam int MODE_W = 4;
	localparam int HALL_SRC_LSB = 12;
	localparam int HALL_SRC_W = 3;
	localparam int DELAY_BYPASS_BIT = 15;

	// status register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_HALL_LSB = 3;

	// reset values
	localparam logic [15:0] MODE_SEL_RST = 16'h0000;
	localparam logic [15:0] VALUE_RST = 16'h0000;
	localparam logic [5:0] DEADTIME_RST = 6'h00;

	// hall sampling point on the channel 0 dead-time counter
	localparam logic [5:0] HALL_SAMPLE_CNT = 6'h01;

	// channel modes
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_CMP_PIN = 4'h1;
	localparam logic [3:0] MODE_CMP_COMP = 4'h2;
	localparam logic [3:0] MODE_CMP_BOTH = 4'h3;
	localparam logic [3:0] MODE_DBL_SPLIT = 4'h4;
	localparam logic [3:0] MODE_DBL_RISE = 4'h5;
	localparam logic [3:0] MODE_DBL_FALL = 4'h6;
	localparam logic [3:0] MODE_DBL_ANY = 4'h7;
	localparam logic [3:0] MODE_HALL = 4'h8;
	localparam logic [3:0] MODE_HYST = 4'h9;
	localparam logic [3:0] MODE_MI_RF = 4'ha;
	localparam logic [3:0] MODE_MI_FR = 4'hb;
	localparam logic [3:0] MODE_MI_RR = 4'hc;
	localparam logic [3:0] MODE_MI_FF = 4'hd;
	localparam logic [3:0] MODE_MI_ANY = 4'he;
	localparam logic [3:0] MODE_RSVD = 4'hf;

	// hall sampling sources
	localparam logic [2:0] HSRC_POS_EDGE = 3'h0;
	localparam logic [2:0] HSRC_SEC_CMP = 3'h1;
	localparam logic [2:0] HSRC_SEC_PER = 3'h2;
	localparam logic [2:0] HSRC_NONE = 3'h3;
	localparam logic [2:0] HSRC_PER_UP = 3'h4;
	localparam logic [2:0] HSRC_ONE_DOWN = 3'h5;
	localparam logic [2:0] HSRC_CMP0_UP = 3'h6;
	localparam logic [2:0] HSRC_UNDEF = 3'h7;

endpackage

// >>> rtl/ccm_edge_if.sv
`timescale 1ns/100ps
// levels and edge pulses of the channel pins and position inputs
interface ccm_edge_if #(parameter int N = 6);
	logic [N-1:0] raw; // inputs as they arrive
	logic [N-1:0] level; // sampled level
	logic [N-1:0] rise; // one-cycle rising edge pulse
	logic [N-1:0] fall; // one-cycle falling edge pulse
	modport det (input raw, output level, rise, fall);
	modport use_side (output raw, input level, rise, fall);
endinterface

// >>> rtl/ccm_edge_det.sv
`timescale 1ns/100ps
// edge detector: current sample against the previous cycle's sample
module ccm_edge_det #(
	parameter int N = 6
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// inputs and edges
	ccm_edge_if.det e
);
	logic [N-1:0] cur_ff; // this cycle's sample
	logic [N-1:0] prev_ff; // last cycle's sample

	// sample and delay one cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cur_ff <= '0;
			prev_ff <= '0;
		end
		else
		begin
			cur_ff <= e.raw;
			prev_ff <= cur_ff;
		end
	end

	// one generate loop over every input bit
	for (genvar i = 0; i < N; i++)
	begin : g_bit
		assign e.rise[i] = cur_ff[i] & ~prev_ff[i];
		assign e.fall[i] = ~cur_ff[i] & prev_ff[i];
	end
	assign e.level = cur_ff;
endmodule

// >>> sim/ccm_top_monitor.sv
`timescale 1ns/100ps
// bus and pin-enable watcher for the mode block
module ccm_top_monitor #(
	parameter int CW = 16,
	parameter int DTW = 6
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// pins
	input wire logic [2:0] chan_pin_i,
	input wire logic [2:0] chan_pin_o,
	input wire logic [2:0] chan_pin_oe_n_o,
	input wire logic [2:0] chan_complement_pin_o,
	input wire logic [2:0] chan_complement_pin_oe_n_o,
	input wire logic [2:0] position_input_i,
	input wire logic second_timer_cmp_i,
	input wire logic second_timer_per_i
);
	logic [15:0] mode_h; // mirror of channel_mode_select
	logic take; // request taken at this edge
	logic unm; // address without a register
	logic [3:0] m0; // channel 0 mode
	logic [2:0] po; // pin enables, active low
	logic [2:0] co; // complement enables, active low
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign unm = !(wb_adr_i inside {8'h00, 8'h14, 8'h18, 8'h1c, 8'h24, 8'h2c, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h78, 8'h80});
	assign m0 = mode_h[3:0];
	assign po = chan_pin_oe_n_o;
	assign co = chan_complement_pin_oe_n_o;
	// mode writes land at the edge that takes them
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mode_h <= ccm_pkg::MODE_SEL_RST;
		else if (take && wb_we_i && wb_adr_i == ccm_pkg::OFS_MODE_SEL)
			mode_h <= wb_dat_i[15:0];
	end
	default clocking dcb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	chk_ack_pulse:
		assert property (take |-> ##1 wb_ack_o ##1 !wb_ack_o) else $error("ack not a one-cycle answer");
	chk_unmapped_zero:
		assert property (take && !wb_we_i && unm |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	chk_mode_layout:
		assert property (take && !wb_we_i && wb_adr_i == ccm_pkg::OFS_MODE_SEL |=> wb_dat_o == {16'h0000, mode_h})
			else $error("mode select readback wrong");
	chk_off_idle:
		assert property (m0 == ccm_pkg::MODE_OFF && $stable(m0) |-> po[0] && co[0]) else $error("off mode drives");
	chk_route_pin:
		assert property (m0 == ccm_pkg::MODE_CMP_PIN && $stable(m0) |-> !po[0] && co[0]) else $error("pin route");
	chk_route_comp:
		assert property (m0 == ccm_pkg::MODE_CMP_COMP && $stable(m0) |-> po[0] && !co[0]) else $error("comp route");
	chk_route_both:
		assert property (m0 == ccm_pkg::MODE_CMP_BOTH && $stable(m0) |-> !po[0] && !co[0]) else $error("both route");
	chk_dbl_comp_io:
		assert property (m0[3:2] == 2'b01 && $stable(m0) |-> co[0]) else $error("capture mode drives complement");
	chk_rsvd_quiet:
		assert property (m0 == ccm_pkg::MODE_RSVD && $stable(m0) |-> po[0] && co[0]) else $error("reserved mode drives");
	cover property (take && wb_we_i && wb_adr_i == ccm_pkg::OFS_MODE_SEL);
	cover property (take && !wb_we_i && unm);
	cover property (mode_h[11:0] == 12'h888);
endmodule

bind ccm_top ccm_top_monitor #(.CW(CW), .DTW(DTW)) u_ccm_top_monitor (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chan_pin_i(chan_pin_i),
	.chan_pin_o(chan_pin_o), .chan_pin_oe_n_o(chan_pin_oe_n_o), .chan_complement_pin_o(chan_complement_pin_o),
	.chan_complement_pin_oe_n_o(chan_complement_pin_oe_n_o), .position_input_i(position_input_i),
	.second_timer_cmp_i(second_timer_cmp_i), .second_timer_per_i(second_timer_per_i));

// >>> sim/ccm_sensor_model.sv
`timescale 1ns/100ps
// hall sensors, position inputs and capture signals
module ccm_sensor_model (
	// clock
	input wire logic clk_i,
	// levels toward the block
	output logic [2:0] chan_pin_o,
	output logic [2:0] position_input_o
);
	// all lines low at start
	initial
	begin
		chan_pin_o = 3'h0;
		position_input_o = 3'h0;
	end
	// move levels after an edge, then hold them lag cycles
	task automatic drive(input logic [2:0] pin, input logic [2:0] pos, input int lag);
		@(posedge clk_i);
		chan_pin_o <= pin;
		position_input_o <= pos;
		repeat (lag) @(posedge clk_i);
	endtask
endmodule

// >>> sim/tb_ccm_top.sv
`timescale 1ns/100ps
// bench for the capture/compare mode block
module tb_ccm_top;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [2:0] pin, pos, pin_o, pin_oe_n, comp_o, comp_oe_n;
	logic down_seen;
	int fails, num_checks;
	// 250 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	ccm_top u_ccm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(4'h3), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.chan_pin_i(pin), .chan_pin_o(pin_o), .chan_pin_oe_n_o(pin_oe_n), .chan_complement_pin_o(comp_o),
		.chan_complement_pin_oe_n_o(comp_oe_n), .position_input_i(pos), .second_timer_cmp_i(1'b0),
		.second_timer_per_i(1'b0));
	ccm_sensor_model u_ccm_sensor_model (.clk_i(clk_i), .chan_pin_o(pin), .position_input_o(pos));
	// one classic cycle; request held until ack is sampled high at a rising edge
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [15:0] dat);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= {16'h0000, dat};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 40);
		if (n >= 40)
		begin
			$display("[ERR] ack expected 1 seen 0");
			fails++;
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	// compare and count
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask
	// read a register and compare its low half
	task automatic rdchk(input string what, input logic [7:0] adr, input logic [15:0] exp);
		xfer(1'b0, adr, 16'h0000);
		chk(what, exp, rd[15:0]);
	endtask
	// reset value, field layout, unmapped place
	task automatic t_map;
		rdchk("mode_sel reset", ccm_pkg::OFS_MODE_SEL, 16'h0000);
		xfer(1'b1, ccm_pkg::OFS_MODE_SEL, 16'hb8a5);
		rdchk("mode_sel fields", ccm_pkg::OFS_MODE_SEL, 16'hb8a5);
		xfer(1'b0, 8'h44, 16'h0000);
		chk("unmapped lo", 16'h0000, rd[15:0]);
		chk("unmapped hi", 16'h0000, rd[31:16]);
		$display("test map done");
	endtask
	// pin routing of compare, off and reserved modes
	task automatic t_route;
		logic [3:0] ml [5];
		logic [3:0] m;
		ml = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hf};
		foreach (ml[i])
		begin
			m = ml[i];
			xfer(1'b1, ccm_pkg::OFS_MODE_SEL, {12'h000, m});
			repeat (3) @(negedge clk_i);
			chk("pin oe_n", {15'h0, !(m == 4'h1 || m == 4'h3)}, {15'h0, pin_oe_n[0]});
			chk("comp oe_n", {15'h0, !(m == 4'h2 || m == 4'h3)}, {15'h0, comp_oe_n[0]});
		end
		$display("test route done");
	endtask
	// counter write guard and both alignments
	task automatic t_timer;
		xfer(1'b1, ccm_pkg::OFS_MODE_SEL, 16'h0000);
		xfer(1'b1, ccm_pkg::OFS_PERIOD, 16'h0008);
		xfer(1'b1, ccm_pkg::OFS_COUNT, 16'h0005);
		rdchk("count stopped", ccm_pkg::OFS_COUNT, 16'h0005);
		xfer(1'b1, ccm_pkg::OFS_CTRL, 16'h0001);
		xfer(1'b1, ccm_pkg::OFS_COUNT, 16'h5555);
		repeat (8)
		begin
			xfer(1'b0, ccm_pkg::OFS_COUNT, 16'h0000);
			chk("count in period", 16'h0001, {15'h0, rd[15:0] <= 16'h0008});
			xfer(1'b0, ccm_pkg::OFS_CTRL, 16'h0000);
			chk("edge mode up", 16'h0000, {15'h0, rd[3]});
		end
		xfer(1'b1, ccm_pkg::OFS_CTRL, 16'h0003);
		down_seen = 1'b0;
		repeat (12)
		begin
			xfer(1'b0, ccm_pkg::OFS_CTRL, 16'h0000);
			down_seen = down_seen | rd[3];
		end
		chk("center turns down", 16'h0001, {15'h0, down_seen});
		xfer(1'b1, ccm_pkg::OFS_CTRL, 16'h0000);
		$display("test timer done");
	endtask
	// compare output on the channel pin while the timer runs
	task automatic t_cmp;
		logic hi, lo;
		hi = 1'b0;
		lo = 1'b0;
		xfer(1'b1, ccm_pkg::OFS_SHADOW0, 16'h0003);
		xfer(1'b1, ccm_pkg::OFS_MODE_SEL, 16'h0001);
		xfer(1'b1, ccm_pkg::OFS_CTRL, 16'h0001);
		repeat (30)
		begin
			@(negedge clk_i);
			hi = hi | pin_o[0];
			lo = lo | !comp_o[0];
		end
		xfer(1'b1, ccm_pkg::OFS_CTRL, 16'h0000);
		chk("pin goes active", 16'h0001, {15'h0, hi});
		chk("complement drops", 16'h0001, {15'h0, lo});
		$display("test compare done");
	endtask
	// double-register capture and refusing modes, timer stopped
	task automatic t_dbl;
		xfer(1'b1, ccm_pkg::OFS_COUNT, 16'h1234);
		xfer(1'b1, ccm_pkg::OFS_MODE_SEL, 16'h0004);
		u_ccm_sensor_model.drive(3'h1, 3'h0, 4);
		rdchk("rise to main", ccm_pkg::OFS_MAIN0, 16'h1234);
		u_ccm_sensor_model.drive(3'h0, 3'h0, 4);
		rdchk("fall to shadow", ccm_pkg::OFS_SHADOW0, 16'h1234);
		xfer(1'b1, ccm_pkg::OFS_MODE_SEL, 16'h0005);
		xfer(1'b1, ccm_pkg::OFS_SHADOW0, 16'h0055);
		xfer(1'b1, ccm_pkg::OFS_COUNT, 16'h0200);
		u_ccm_sensor_model.drive(3'h1, 3'h0, 4);
		rdchk("shadow to main", ccm_pkg::OFS_MAIN0, 16'h0055);
		rdchk("count to shadow", ccm_pkg::OFS_SHADOW0, 16'h0200);
		u_ccm_sensor_model.drive(3'h0, 3'h0, 4);
		rdchk("fall ignored", ccm_pkg::OFS_MAIN0, 16'h0055);
		xfer(1'b1, ccm_pkg::OFS_MODE_SEL, 16'h000f);
		u_ccm_sensor_model.drive(3'h1, 3'h0, 4);
		rdchk("reserved no capture", ccm_pkg::OFS_MAIN0, 16'h0055);
		xfer(1'b1, ccm_pkg::OFS_MODE_SEL, 16'h0000);
		u_ccm_sensor_model.drive(3'h0, 3'h0, 4);
		rdchk("off no capture", ccm_pkg::OFS_MAIN0, 16'h0055);
		$display("test double done");
	endtask
	// multi-input capture on channels 1 and 2
	task automatic t_multi;
		xfer(1'b1, ccm_pkg::OFS_MODE_SEL, 16'h0ac0);
		xfer(1'b1, ccm_pkg::OFS_COUNT, 16'h0abc);
		u_ccm_sensor_model.drive(3'h6, 3'h6, 4);
		rdchk("ch1 main", 8'h38, 16'h0abc);
		rdchk("ch1 shadow", 8'h18, 16'h0abc);
		rdchk("ch2 main", 8'h3c, 16'h0abc);
		rdchk("ch2 shadow idle", 8'h1c, 16'h0000);
		xfer(1'b1, ccm_pkg::OFS_COUNT, 16'h0def);
		u_ccm_sensor_model.drive(3'h6, 3'h2, 4);
		rdchk("ch2 shadow", 8'h1c, 16'h0def);
		rdchk("ch1 shadow held", 8'h18, 16'h0abc);
		$display("test multi done");
	endtask
	// hall capture by software trigger and by delayed edge
	task automatic t_hall;
		xfer(1'b1, ccm_pkg::OFS_MODE_SEL, 16'hf888);
		xfer(1'b1, ccm_pkg::OFS_COUNT, 16'h0321);
		u_ccm_sensor_model.drive(3'h0, 3'h5, 6);
		rdchk("no hw trigger", ccm_pkg::OFS_MAIN0, 16'h0055);
		xfer(1'b1, ccm_pkg::OFS_CTRL, 16'h0004);
		rdchk("hall capture", ccm_pkg::OFS_MAIN0, 16'h0321);
		rdchk("hall count reset", ccm_pkg::OFS_COUNT, 16'h0000);
		xfer(1'b1, ccm_pkg::OFS_DEADTIME, 16'h0003);
		xfer(1'b1, ccm_pkg::OFS_MODE_SEL, 16'h0888);
		xfer(1'b1, ccm_pkg::OFS_COUNT, 16'h0777);
		u_ccm_sensor_model.drive(3'h0, 3'h3, 20);
		rdchk("delayed capture", ccm_pkg::OFS_MAIN0, 16'h0777);
		$display("test hall done");
	endtask
	// counts and verdict
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// reset, then the tests
	initial
	begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		fails = 0;
		num_checks = 0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_map;
		t_route;
		t_timer;
		t_cmp;
		t_dbl;
		t_multi;
		t_hall;
		summarize;
	end
	// watchdog: tests need about 400 cycles, cut at 20000
	initial
	begin
		#80000;
		fails++;
		summarize;
	end
endmodule
